//--- ged_pkg.sv
// Package: constants and carrier types for the GPIO edge detect latch
`default_nettype none

package ged_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Sizes
   localparam int PORT_W   = 8;                     // Pins per port
   localparam int NUM_PORT = 3;                     // Ports 0, 1 and 3
   localparam int ADDR_W   = 16;                    // Register address width
   localparam int DATA_W   = 8;                     // Register data width

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets, index 0..2 stands for port 0, 1, 3
   localparam logic [15:0] PORT0_RISE_DETECT = 16'ha028;
   localparam logic [15:0] PORT1_RISE_DETECT = 16'ha029;
   localparam logic [15:0] PORT3_RISE_DETECT = 16'ha02b;
   localparam logic [15:0] PORT0_FALL_DETECT = 16'ha038;
   localparam logic [15:0] PORT1_FALL_DETECT = 16'ha039;
   localparam logic [15:0] PORT3_FALL_DETECT = 16'ha03b;
   localparam logic [15:0] PIN_IRQ_ENABLE    = 16'ha040; // Mask, bit k = port index k
   localparam logic [15:0] PIN_IRQ_STATUS    = 16'ha041; // Sticky, write one to clear
   localparam logic [15:0] PORT0_LEVEL       = 16'ha044; // Filtered pin levels
   localparam logic [15:0] PORT1_LEVEL       = 16'ha045;
   localparam logic [15:0] PORT3_LEVEL       = 16'ha047;

   localparam logic [NUM_PORT-1:0][15:0] RISE_ADDR =
      {PORT3_RISE_DETECT, PORT1_RISE_DETECT, PORT0_RISE_DETECT};
   localparam logic [NUM_PORT-1:0][15:0] FALL_ADDR =
      {PORT3_FALL_DETECT, PORT1_FALL_DETECT, PORT0_FALL_DETECT};
   localparam logic [NUM_PORT-1:0][15:0] LEVEL_ADDR =
      {PORT3_LEVEL, PORT1_LEVEL, PORT0_LEVEL};

   ////////////////////////////////////////////////////////////////////////////
   // Values after reset
   localparam logic [7:0] DETECT_RESET = 8'h00;
   localparam logic [2:0] IRQ_RESET    = 3'h0;
   localparam logic [7:0] RDATA_IDLE   = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Carrier types
   typedef struct packed {
      logic        wr;                              // Write strobe
      logic        rd;                              // Read strobe
      logic [15:0] addr;                            // Byte address
      logic [7:0]  wdata;                           // Write data
   } ged_bus_req_type;

   typedef struct packed {
      logic [7:0] rise_en;                          // Rising detection enables
      logic [7:0] fall_en;                          // Falling detection enables
      logic [7:0] rise_clr;                         // Rising flags to clear
      logic [7:0] fall_clr;                         // Falling flags to clear
   } ged_lane_ctl_type;

   typedef struct packed {
      logic [7:0] rise_flags;                       // Latched rising flags
      logic [7:0] fall_flags;                       // Latched falling flags
      logic [7:0] level;                            // Filtered pin level
   } ged_lane_stat_type;

endpackage : ged_pkg

`default_nettype wire

//--- ged_edge_lane.sv
// Module: one port of eight pins, synchroniser, edge detect and flag latch
`timescale 1ns/1ps
`default_nettype none

module ged_edge_lane (
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic [7:0]                pins,
   input  wire ged_pkg::ged_lane_ctl_type ctl,
   output var  ged_pkg::ged_lane_stat_type stat
);

   typedef struct packed {
      logic [7:0] s1;                               // First sync stage
      logic [7:0] s2;                               // Second sync stage
      logic [7:0] s3;                               // Third sync stage
      logic [7:0] level;                            // Last accepted level
      logic [7:0] rise;                             // Rising flags
      logic [7:0] fall;                             // Falling flags
   } ged_lane_state_type;

   ged_lane_state_type state;
   ged_lane_state_type next_state;
   logic [7:0]         agree;
   logic [7:0]         rise_evt;
   logic [7:0]         fall_evt;

   ////////////////////////////////////////////////////////////////////////////
   // Per pin edge logic; a change counts once stages two and three agree
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_pin
         assign agree[i]    = state.s2[i] == state.s3[i];
         assign rise_evt[i] = agree[i] & state.s3[i] & ~state.level[i];
         assign fall_evt[i] = agree[i] & ~state.s3[i] & state.level[i];
      end
   endgenerate

   // Next state; a set in the clear cycle wins so no edge is lost
   always_comb begin
      next_state       = state;
      next_state.s1    = pins;
      next_state.s2    = state.s1;
      next_state.s3    = state.s2;
      next_state.level = (state.level & ~agree) | (state.s3 & agree);
      next_state.rise  = (state.rise & ~ctl.rise_clr) | (rise_evt & ctl.rise_en);
      next_state.fall  = (state.fall & ~ctl.fall_clr) | (fall_evt & ctl.fall_en);
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign stat.rise_flags = state.rise;
   assign stat.fall_flags = state.fall;
   assign stat.level      = state.level;

endmodule : ged_edge_lane

`default_nettype wire

//--- ged_edge_latch.sv
// Module: top of the GPIO edge detect latch for ports 0, 1 and 3
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module ged_edge_latch (
   input  wire logic                     CORE_CLK,
   input  wire logic                     RSTN,
   input  wire logic [7:0]               PORT0_IN,
   input  wire logic [7:0]               PORT1_IN,
   input  wire logic [7:0]               PORT3_IN,
   input  wire ged_pkg::ged_bus_req_type BUS_REQ,
   output logic      [7:0]               RDATA,
   output logic                          PIN_IRQ
);

   ////////////////////////////////////////////////////////////////////////////
   // Types and signals

   typedef struct packed {
      logic [2:0][7:0] rise_en;                     // Rising enables per port
      logic [2:0][7:0] fall_en;                     // Falling enables per port
      logic [2:0]      irq_mask;                    // Port pin interrupt enables
      logic [2:0]      irq_stat;                    // Sticky port events
      logic [7:0]      rdata;                       // Read data, one cycle late
      logic            irq;                         // Registered interrupt
   } ged_top_state_type;

   ged_top_state_type              state;
   ged_top_state_type              next_state;
   logic                           rst_meta;
   logic                           rst_sync;
   logic [2:0][7:0]                pin_bus;
   ged_pkg::ged_lane_ctl_type [2:0]  lane_ctl;
   ged_pkg::ged_lane_stat_type [2:0] lane_stat;
   logic [2:0]                     hit_rise;
   logic [2:0]                     hit_fall;
   logic [2:0]                     hit_level;
   logic                           hit_mask;
   logic                           hit_stat;
   logic [2:0]                     port_pending;

   ////////////////////////////////////////////////////////////////////////////
   // Reset release through two flops; assertion stays asynchronous

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin lanes

   // Index 2 carries port 3; there is no port 2 in this block
   assign pin_bus[0] = PORT0_IN;
   assign pin_bus[1] = PORT1_IN;
   assign pin_bus[2] = PORT3_IN;

   genvar p;
   generate
      for (p = 0; p < ged_pkg::NUM_PORT; p++) begin : g_port
         // Address hits for this port
         assign hit_rise[p]  = BUS_REQ.addr == ged_pkg::RISE_ADDR[p];
         assign hit_fall[p]  = BUS_REQ.addr == ged_pkg::FALL_ADDR[p];
         assign hit_level[p] = BUS_REQ.addr == ged_pkg::LEVEL_ADDR[p];

         // Enables steer detection; writing a zero clears the matching flag
         assign lane_ctl[p].rise_en  = state.rise_en[p];
         assign lane_ctl[p].fall_en  = state.fall_en[p];
         assign lane_ctl[p].rise_clr = (BUS_REQ.wr & hit_rise[p]) ? ~BUS_REQ.wdata : 8'h00;
         assign lane_ctl[p].fall_clr = (BUS_REQ.wr & hit_fall[p]) ? ~BUS_REQ.wdata : 8'h00;

         // Any latched flag keeps the port's event pending
         assign port_pending[p] = |lane_stat[p].rise_flags
                                | |lane_stat[p].fall_flags;

         ged_edge_lane u_lane (
            .clk   (CORE_CLK),
            .rst_n (rst_sync),
            .pins  (pin_bus[p]),
            .ctl   (lane_ctl[p]),
            .stat  (lane_stat[p])
         );
      end
   endgenerate

   assign hit_mask    = BUS_REQ.addr == ged_pkg::PIN_IRQ_ENABLE;
   assign hit_stat    = BUS_REQ.addr == ged_pkg::PIN_IRQ_STATUS;

   ////////////////////////////////////////////////////////////////////////////
   // Register writes, readback and interrupt

   // Writes land in enables; a zero bit written to a detect register also clears its flag
   always_comb begin
      next_state       = state;
      next_state.rdata = ged_pkg::RDATA_IDLE;

      for (int k = 0; k < ged_pkg::NUM_PORT; k++) begin
         if (BUS_REQ.wr && hit_rise[k]) begin
            next_state.rise_en[k] = BUS_REQ.wdata;
         end
         if (BUS_REQ.wr && hit_fall[k]) begin
            next_state.fall_en[k] = BUS_REQ.wdata;
         end
      end

      if (BUS_REQ.wr && hit_mask) begin
         next_state.irq_mask = BUS_REQ.wdata[2:0];
      end

      // Sticky status: write one clears, a pending port sets it again;
      // the clear only sticks once the port's flags are gone
      next_state.irq_stat = state.irq_stat;
      if (BUS_REQ.wr && hit_stat) begin
         next_state.irq_stat = state.irq_stat & ~BUS_REQ.wdata[2:0];
      end
      next_state.irq_stat = next_state.irq_stat | port_pending;

      // Read mux; unmapped addresses answer zero
      if (BUS_REQ.rd) begin
         for (int k = 0; k < ged_pkg::NUM_PORT; k++) begin
            if (hit_rise[k]) begin
               next_state.rdata = lane_stat[k].rise_flags;
            end
            if (hit_fall[k]) begin
               next_state.rdata = lane_stat[k].fall_flags;
            end
            if (hit_level[k]) begin
               next_state.rdata = lane_stat[k].level;
            end
         end
         if (hit_mask) begin
            next_state.rdata = {5'h00, state.irq_mask};
         end
         if (hit_stat) begin
            next_state.rdata = {5'h00, state.irq_stat};
         end
      end

      // Level interrupt, one cycle after the status bit it follows
      next_state.irq = |(state.irq_stat & state.irq_mask);
   end

   // Whole top state in one register; enables reset to zero
   always_ff @(posedge CORE_CLK or negedge rst_sync) begin
      if (!rst_sync) begin
         state.rise_en  <= {3{ged_pkg::DETECT_RESET}};
         state.fall_en  <= {3{ged_pkg::DETECT_RESET}};
         state.irq_mask <= ged_pkg::IRQ_RESET;
         state.irq_stat <= ged_pkg::IRQ_RESET;
         state.rdata    <= ged_pkg::RDATA_IDLE;
         state.irq      <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from flops

   assign RDATA   = state.rdata;
   assign PIN_IRQ = state.irq;

endmodule : ged_edge_latch

`default_nettype wire

//--- ged_pin_model.sv
// Pin model: external levels on ports 0, 1 and 3, set by the bench
`timescale 1ns/1ps
`default_nettype none

module ged_pin_model (
   input  wire logic       clk,
   input  wire logic       load,
   input  wire logic [1:0] sel,
   input  wire logic [7:0] val,
   output wire logic [7:0] p0,
   output wire logic [7:0] p1,
   output wire logic [7:0] p3
);
   logic [7:0] lv [3] = '{default: 8'h00};
   // New level only just after an edge, so no pin races the sampler
   always @(posedge clk) if (load) lv[sel] <= val;
   assign p0 = lv[0];
   assign p1 = lv[1];
   assign p3 = lv[2];
endmodule : ged_pin_model
`default_nettype wire

//--- ged_edge_latch_checker.sv
// Checker: read data, flag clear and interrupt timing at the latch ports
`timescale 1ns/1ps
`default_nettype none

module ged_edge_latch_checker (
   input wire logic                     CORE_CLK,
   input wire logic                     RSTN,
   input wire logic [7:0]               PORT0_IN,
   input wire logic [7:0]               PORT1_IN,
   input wire logic [7:0]               PORT3_IN,
   input wire ged_pkg::ged_bus_req_type BUS_REQ,
   input wire logic [7:0]               RDATA,
   input wire logic                     PIN_IRQ
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);
   // Clear write, idle cycle, read back of the same register
   sequence s_clear(a);
      BUS_REQ.wr && BUS_REQ.addr == a && BUS_REQ.wdata == 8'h00 ##2 BUS_REQ.rd && BUS_REQ.addr == a;
   endsequence
   chk_rdata_idle: assert property (!BUS_REQ.rd |=> RDATA == 8'h00)
      else $error("read data not idle");
   chk_unmapped_zero: assert property (BUS_REQ.rd && !(BUS_REQ.addr inside {16'ha028, 16'ha029, 16'ha02b,
      16'ha038, 16'ha039, 16'ha03b, 16'ha040, 16'ha041, 16'ha044, 16'ha045, 16'ha047}) |=> RDATA == 8'h00)
      else $error("unmapped read not zero");
   chk_rise0_clear: assert property (s_clear(16'ha028) |=> RDATA == 8'h00)
      else $error("port 0 rising flags not cleared");
   chk_fall1_clear: assert property (s_clear(16'ha039) |=> RDATA == 8'h00)
      else $error("port 1 falling flags not cleared");
   chk_fall3_clear: assert property (s_clear(16'ha03b) |=> RDATA == 8'h00)
      else $error("port 3 falling flags not cleared");
   chk_mask_off_irq: assert property (BUS_REQ.wr && BUS_REQ.addr == 16'ha040 && BUS_REQ.wdata[2:0] == 3'h0
      |=> ##1 !PIN_IRQ) else $error("interrupt stays with mask off");
   chk_irq_fall_cause: assert property ($fell(PIN_IRQ) |-> $past(BUS_REQ.wr, 2))
      else $error("interrupt dropped without a write");
   chk_irq_after_reset: assert property ($rose(RSTN) |-> !PIN_IRQ [*3])
      else $error("interrupt high after reset");
endmodule : ged_edge_latch_checker

bind ged_edge_latch ged_edge_latch_checker u_chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .PORT0_IN(PORT0_IN),
   .PORT1_IN(PORT1_IN), .PORT3_IN(PORT3_IN), .BUS_REQ(BUS_REQ), .RDATA(RDATA), .PIN_IRQ(PIN_IRQ));
`default_nettype wire

//--- ged_edge_latch_bench.sv
// Bench: registers, edge flags and pin interrupt of the edge latch
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module ged_edge_latch_bench;
   logic                     clk = 1'b0;
   logic                     rstn = 1'b0;
   logic                     load = 1'b0;
   logic [1:0]               sel = 2'h0;
   logic [7:0]               val = 8'h00;
   ged_pkg::ged_bus_req_type req = '0;
   wire logic [7:0]          p0, p1, p3, rdata;
   wire logic                irq;
   int                       bad_count = 0;
   int                       compares = 0;
   int                       cyc = 0;
   always #10 clk = ~clk;
   ged_pin_model pins (.clk(clk), .load(load), .sel(sel), .val(val), .p0(p0), .p1(p1), .p3(p3));
   ged_edge_latch dut (.CORE_CLK(clk), .RSTN(rstn), .PORT0_IN(p0), .PORT1_IN(p1), .PORT3_IN(p3),
      .BUS_REQ(req), .RDATA(rdata), .PIN_IRQ(irq));
   ////////////////////////////////////////////////////////////////////////////
   // Drivers; each leaves an idle edge so two strobes never merge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      req <= '0;
      #1;
      `CHK(rdata, e)
      @(posedge clk);
   endtask : rd
   task automatic pin(input int s, input logic [7:0] v);
      load <= 1'b1;
      sel <= 2'(s);
      val <= v;
      @(posedge clk);
      load <= 1'b0;
      @(posedge clk);
   endtask : pin
   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      for (int k = 0; k < 3; k++) begin
         rd(ged_pkg::RISE_ADDR[k], 8'h00);
         rd(ged_pkg::FALL_ADDR[k], 8'h00);
      end
      rd(16'ha028, 8'h00);
      wr(16'ha02a, 8'hff);
      rd(16'ha02a, 8'h00);
      `CHK(irq, 1'b0)
      $display("test reset done");
   endtask : t_reset
   task automatic t_edges();
      logic [15:0] ra;
      logic [15:0] fa;
      for (int k = 0; k < 3; k++) begin
         ra = ged_pkg::RISE_ADDR[k];
         fa = ged_pkg::FALL_ADDR[k];
         pin(k, 8'h3c);
         tick(4);
         wr(ra, 8'hff);
         wr(fa, 8'hff);
         rd(ra, 8'h00);
         pin(k, 8'h5a);
         rd(ra, 8'h00);
         tick(3);
         rd(ra, 8'h42);
         rd(fa, 8'h24);
         rd(ged_pkg::LEVEL_ADDR[k], 8'h5a);
         pin(k, 8'h00);
         tick(4);
         rd(ra, 8'h42);
         rd(fa, 8'h7e);
         wr(ra, 8'h0f);
         rd(ra, 8'h02);
         rd(fa, 8'h7e);
         wr(fa, 8'h00);
         rd(fa, 8'h00);
         wr(ra, 8'h00);
         rd(ra, 8'h00);
         rd(ged_pkg::LEVEL_ADDR[k], 8'h00);
      end
      $display("test edges done");
   endtask : t_edges
   task automatic t_irq();
      wr(16'ha041, 8'h07);
      wr(16'ha029, 8'h01);
      pin(1, 8'h01);
      tick(6);
      `CHK(irq, 1'b0)
      rd(16'ha041, 8'h02);
      wr(16'ha040, 8'h02);
      tick(1);
      `CHK(irq, 1'b1)
      wr(16'ha029, 8'h00);
      wr(16'ha041, 8'h02);
      tick(1);
      `CHK(irq, 1'b0)
      pin(2, 8'h80);
      tick(4);
      wr(16'ha03b, 8'h80);
      wr(16'ha040, 8'h04);
      rd(16'ha040, 8'h04);
      pin(2, 8'h00);
      tick(6);
      `CHK(irq, 1'b1)
      rd(16'ha041, 8'h04);
      wr(16'ha040, 8'h00);
      tick(1);
      `CHK(irq, 1'b0)
      $display("test irq done");
   endtask : t_irq
   task automatic end_sim();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   // Main sequence after ten cycles of reset
   initial begin
      tick(10);
      rstn <= 1'b1;
      tick(3);
      t_reset();
      t_edges();
      t_irq();
      end_sim();
   end
   // Whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc > 3000) begin
         bad_count++;
         end_sim();
      end
   end
endmodule : ged_edge_latch_bench
`default_nettype wire
